// ---- hw/tx_symbol_pkg.sv ----
package tx_symbol_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_RATE   = 8'h4c;
    localparam logic [7:0] ADDR_P0_HI  = 8'h4d;
    localparam logic [7:0] ADDR_P0_LO  = 8'h4e;
    localparam logic [7:0] ADDR_P1_HI  = 8'h4f;
    localparam logic [7:0] ADDR_P1_LO  = 8'h50;
    localparam logic [7:0] ADDR_P2     = 8'h51;
    localparam logic [7:0] ADDR_P3     = 8'h52;
    localparam logic [7:0] ADDR_LEN01  = 8'h53;
    localparam logic [7:0] ADDR_LEN23  = 8'h54;

    // ------------------------------------------------------------
    // reset values and field masks
    // ------------------------------------------------------------
    localparam logic [7:0] RST_BYTE    = 8'h00;
    localparam logic [7:0] LEN23_MASK  = 8'h77;
    localparam logic [7:0] READ_NONE   = 8'h00;

    // ------------------------------------------------------------
    // rate codes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        RATE_RSV0 = 3'h0,
        RATE_RSV1 = 3'h1,
        RATE_26K  = 3'h2,
        RATE_53K  = 3'h3,
        RATE_106K = 3'h4,
        RATE_212K = 3'h5,
        RATE_424K = 3'h6,
        RATE_848K = 3'h7
    } bit_rate_t;

    typedef enum logic {
        SC_424K = 1'b0,
        SC_848K = 1'b1
    } subcarrier_t;

    typedef struct packed {
        subcarrier_t upper_pair_subcarrier_rate;
        bit_rate_t   upper_pair_bit_rate;
        subcarrier_t lower_pair_subcarrier_rate;
        bit_rate_t   lower_pair_bit_rate;
    } rate_fields_t;

    typedef struct packed {
        logic [15:0] pattern;
        logic [4:0]  count;
    } sym16_t;

    typedef struct packed {
        logic [7:0] pattern;
        logic [3:0] count;
    } sym8_t;

endpackage : tx_symbol_pkg

// ---- hw/pattern_mask.sv ----
`timescale 1ns/10ps
// clears pattern bits that lie beyond the valid length, msb first
module pattern_mask #(
    parameter int W  = 16,
    parameter int LW = 4
) (
    // length code, value plus one bits are valid
    input  wire logic [LW-1:0] len_code,
    input  wire logic [W-1:0]  pattern_in,
    // masked pattern and bit count
    output logic      [W-1:0]  pattern_out,
    output logic      [LW:0]   bit_count
);
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            // bit i is valid when it is among the top len_code+1 bits
            assign pattern_out[i] = pattern_in[i] & ((W - 1 - i) <= int'(len_code));
        end
    endgenerate

    assign bit_count = {1'b0, len_code} + {{LW{1'b0}}, 1'b1};
endmodule : pattern_mask

// ---- hw/tx_symbol_pattern_config.sv ----
`timescale 1ns/10ps
// Functional notes
// - rate bit 7 picks upper pair subcarrier: 0 is 424 kHz, 1 is 848 kHz
// - rate bits 6..4 set upper pair bit rate; codes 0 and 1 reserved
// - rate bit 3 picks lower pair subcarrier: 0 is 424 kHz, 1 is 848 kHz
// - rate bits 2..0 set lower pair bit rate, same code table
// - two bytes form the 16-bit pattern of symbol zero
// - symbol zero: lower address is bits 15..8, next address bits 7..0
// - two further bytes form the 16-bit pattern of symbol one
// - symbol one: lower address is bits 15..8, next address bits 7..0
// - one byte register holds the 8-bit pattern of symbol two
// - one byte register holds the 8-bit pattern of symbol three
// - first length bits 7..4: symbol one valid bits, value plus one
// - first length bits 3..0: symbol zero valid bits, value plus one
// - second length bits 6..4: symbol three valid bits, value plus one
// - second length bits 2..0: symbol two valid bits, value plus one
module tx_symbol_pattern_config (
    // clock and reset
    input  wire logic                        clk_sys,
    input  wire logic                        sys_rst,
    // register port
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    input  wire logic [7:0]                  reg_addr,
    input  wire logic [7:0]                  reg_wdata,
    output logic      [7:0]                  reg_rdata_r,
    output logic                             reg_hit_r,
    // symbol generator side
    output tx_symbol_pkg::rate_fields_t      rate_cfg_r,
    output logic                             upper_rate_reserved_r,
    output logic                             lower_rate_reserved_r,
    output tx_symbol_pkg::sym16_t            sym0_r,
    output tx_symbol_pkg::sym16_t            sym1_r,
    output tx_symbol_pkg::sym8_t             sym2_r,
    output tx_symbol_pkg::sym8_t             sym3_r
);

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    logic [7:0] rate_r;
    logic [7:0] p0_hi_r;
    logic [7:0] p0_lo_r;
    logic [7:0] p1_hi_r;
    logic [7:0] p1_lo_r;
    logic [7:0] p2_r;
    logic [7:0] p3_r;
    logic [7:0] len01_r;
    logic [7:0] len23_r;

    function automatic logic is_reserved(input logic [2:0] code);
        is_reserved = (code == tx_symbol_pkg::RATE_RSV0) ||
                      (code == tx_symbol_pkg::RATE_RSV1);
    endfunction : is_reserved

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rate_r  <= tx_symbol_pkg::RST_BYTE;
            p0_hi_r <= tx_symbol_pkg::RST_BYTE;
            p0_lo_r <= tx_symbol_pkg::RST_BYTE;
            p1_hi_r <= tx_symbol_pkg::RST_BYTE;
            p1_lo_r <= tx_symbol_pkg::RST_BYTE;
            p2_r    <= tx_symbol_pkg::RST_BYTE;
            p3_r    <= tx_symbol_pkg::RST_BYTE;
            len01_r <= tx_symbol_pkg::RST_BYTE;
            len23_r <= tx_symbol_pkg::RST_BYTE;
        end
        else if (reg_wr)
        begin
            unique case (reg_addr)
                tx_symbol_pkg::ADDR_RATE:  rate_r  <= reg_wdata;
                tx_symbol_pkg::ADDR_P0_HI: p0_hi_r <= reg_wdata;
                tx_symbol_pkg::ADDR_P0_LO: p0_lo_r <= reg_wdata;
                tx_symbol_pkg::ADDR_P1_HI: p1_hi_r <= reg_wdata;
                tx_symbol_pkg::ADDR_P1_LO: p1_lo_r <= reg_wdata;
                tx_symbol_pkg::ADDR_P2:    p2_r    <= reg_wdata;
                tx_symbol_pkg::ADDR_P3:    p3_r    <= reg_wdata;
                tx_symbol_pkg::ADDR_LEN01: len01_r <= reg_wdata;
                tx_symbol_pkg::ADDR_LEN23: len23_r <= reg_wdata & tx_symbol_pkg::LEN23_MASK;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // read path, one cycle latency
    // ------------------------------------------------------------
    logic [7:0] rd_nxt;
    logic       hit_nxt;

    always_comb
    begin
        hit_nxt = 1'b1;
        unique case (reg_addr)
            tx_symbol_pkg::ADDR_RATE:  rd_nxt = rate_r;
            tx_symbol_pkg::ADDR_P0_HI: rd_nxt = p0_hi_r;
            tx_symbol_pkg::ADDR_P0_LO: rd_nxt = p0_lo_r;
            tx_symbol_pkg::ADDR_P1_HI: rd_nxt = p1_hi_r;
            tx_symbol_pkg::ADDR_P1_LO: rd_nxt = p1_lo_r;
            tx_symbol_pkg::ADDR_P2:    rd_nxt = p2_r;
            tx_symbol_pkg::ADDR_P3:    rd_nxt = p3_r;
            tx_symbol_pkg::ADDR_LEN01: rd_nxt = len01_r;
            tx_symbol_pkg::ADDR_LEN23: rd_nxt = len23_r & tx_symbol_pkg::LEN23_MASK;
            default:
            begin
                rd_nxt  = tx_symbol_pkg::READ_NONE;
                hit_nxt = 1'b0;
            end
        endcase
    end

    // unmapped reads return zero; rdata holds until the next read
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            reg_rdata_r <= tx_symbol_pkg::READ_NONE;
            reg_hit_r   <= 1'b0;
        end
        else if (reg_rd)
        begin
            reg_rdata_r <= rd_nxt;
            reg_hit_r   <= hit_nxt;
        end
    end

    // ------------------------------------------------------------
    // length masking toward the generator
    // ------------------------------------------------------------
    logic [15:0] m0;
    logic [15:0] m1;
    logic [7:0]  m2;
    logic [7:0]  m3;
    logic [4:0]  c0;
    logic [4:0]  c1;
    logic [3:0]  c2;
    logic [3:0]  c3;

    pattern_mask #(.W(16), .LW(4)) u_mask0 (
        .len_code    (len01_r[3:0]),
        .pattern_in  ({p0_hi_r, p0_lo_r}),
        .pattern_out (m0),
        .bit_count   (c0)
    );

    pattern_mask #(.W(16), .LW(4)) u_mask1 (
        .len_code    (len01_r[7:4]),
        .pattern_in  ({p1_hi_r, p1_lo_r}),
        .pattern_out (m1),
        .bit_count   (c1)
    );

    pattern_mask #(.W(8), .LW(3)) u_mask2 (
        .len_code    (len23_r[2:0]),
        .pattern_in  (p2_r),
        .pattern_out (m2),
        .bit_count   (c2)
    );

    pattern_mask #(.W(8), .LW(3)) u_mask3 (
        .len_code    (len23_r[6:4]),
        .pattern_in  (p3_r),
        .pattern_out (m3),
        .bit_count   (c3)
    );

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    // outputs lag register writes by one cycle to stay flop driven
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rate_cfg_r <= '0;
            sym0_r     <= '0;
            sym1_r     <= '0;
            sym2_r     <= '0;
            sym3_r     <= '0;
        end
        else
        begin
            rate_cfg_r <= tx_symbol_pkg::rate_fields_t'(rate_r);
            sym0_r     <= '{pattern: m0, count: c0};
            sym1_r     <= '{pattern: m1, count: c1};
            sym2_r     <= '{pattern: m2, count: c2};
            sym3_r     <= '{pattern: m3, count: c3};
        end
    end

    // reserved rate codes are flagged, not blocked, so software sees what it wrote
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            upper_rate_reserved_r <= 1'b0;
            lower_rate_reserved_r <= 1'b0;
        end
        else
        begin
            upper_rate_reserved_r <= is_reserved(rate_r[6:4]);
            lower_rate_reserved_r <= is_reserved(rate_r[2:0]);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_upper_sc_map: assert property (@(posedge clk_sys) disable iff (sys_rst)
        reg_wr && reg_addr == tx_symbol_pkg::ADDR_RATE ##2 !$past(reg_wr)
        |-> rate_cfg_r.upper_pair_subcarrier_rate == $past(reg_wdata[7], 2))
        else $error("upper subcarrier select mismatch");

    a_upper_rate_map: assert property (@(posedge clk_sys) disable iff (sys_rst)
        reg_wr && reg_addr == tx_symbol_pkg::ADDR_RATE ##2 !$past(reg_wr)
        |-> rate_cfg_r.upper_pair_bit_rate == $past(reg_wdata[6:4], 2))
        else $error("upper bit rate mismatch");

    a_lower_sc_map: assert property (@(posedge clk_sys) disable iff (sys_rst)
        reg_wr && reg_addr == tx_symbol_pkg::ADDR_RATE ##2 !$past(reg_wr)
        |-> rate_cfg_r.lower_pair_subcarrier_rate == $past(reg_wdata[3], 2))
        else $error("lower subcarrier select mismatch");

    a_lower_rate_rsv: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !sys_rst |=> lower_rate_reserved_r
        == (rate_cfg_r.lower_pair_bit_rate < tx_symbol_pkg::RATE_26K))
        else $error("lower reserved flag wrong");

    a_sym0_high_byte: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ##1 sym0_r.count == 5'd16 |-> sym0_r.pattern[15:8] == $past(p0_hi_r))
        else $error("symbol zero high byte misplaced");

    a_sym1_low_byte: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ##1 sym1_r.count == 5'd16 |-> sym1_r.pattern[7:0] == $past(p1_lo_r))
        else $error("symbol one low byte misplaced");

    a_sym2_full: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ##1 sym2_r.count == 4'd8 |-> sym2_r.pattern == $past(p2_r))
        else $error("symbol two pattern wrong");

    a_sym3_full: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ##1 sym3_r.count == 4'd8 |-> sym3_r.pattern == $past(p3_r))
        else $error("symbol three pattern wrong");

    a_len1_count: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !sys_rst |=> sym1_r.count == {1'b0, $past(len01_r[7:4])} + 5'd1)
        else $error("symbol one length wrong");

    a_len0_count: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !sys_rst |=> sym0_r.count == {1'b0, $past(len01_r[3:0])} + 5'd1)
        else $error("symbol zero length wrong");

    a_len3_count: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !sys_rst |=> sym3_r.count == {1'b0, $past(len23_r[6:4])} + 4'd1)
        else $error("symbol three length wrong");

    a_len2_count: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !sys_rst |=> sym2_r.count == {1'b0, $past(len23_r[2:0])} + 4'd1)
        else $error("symbol two length wrong");

    a_rsv_read_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
        reg_rd && reg_addr == tx_symbol_pkg::ADDR_LEN23 |=> reg_rdata_r[7] == 1'b0
        && reg_rdata_r[3] == 1'b0)
        else $error("reserved length bits not zero");

    a_short_sym0_mask: assert property (@(posedge clk_sys) disable iff (sys_rst)
        sym0_r.count == 5'd1 |-> sym0_r.pattern[14:0] == 15'h0000)
        else $error("bits beyond length leaked");

    c_write_rate: cover property (@(posedge clk_sys) disable iff (sys_rst)
        reg_wr && reg_addr == tx_symbol_pkg::ADDR_RATE);
    c_read_len23: cover property (@(posedge clk_sys) disable iff (sys_rst)
        reg_rd && reg_addr == tx_symbol_pkg::ADDR_LEN23);
    c_short_sym1: cover property (@(posedge clk_sys) disable iff (sys_rst)
        sym1_r.count == 5'd3);
    c_unmapped_rd: cover property (@(posedge clk_sys) disable iff (sys_rst)
        reg_rd ##1 !reg_hit_r);

endmodule : tx_symbol_pattern_config

// ---- test/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;

    // ------------------------------------------------------------
    // design hookup
    // ------------------------------------------------------------
    logic                         clk_sys;
    logic                         sys_rst;
    logic                         reg_wr;
    logic                         reg_rd;
    logic [7:0]                   reg_addr;
    logic [7:0]                   reg_wdata;
    logic [7:0]                   reg_rdata_r;
    logic                         reg_hit_r;
    tx_symbol_pkg::rate_fields_t  rate_cfg_r;
    logic                         upper_rate_reserved_r;
    logic                         lower_rate_reserved_r;
    tx_symbol_pkg::sym16_t        sym0_r;
    tx_symbol_pkg::sym16_t        sym1_r;
    tx_symbol_pkg::sym8_t         sym2_r;
    tx_symbol_pkg::sym8_t         sym3_r;
    logic [7:0]                   mem [9];
    logic [8:0]                   rq [$];
    int                           n_mismatch = 0;
    int                           checks = 0;
    int                           cyc = 0;

    tx_symbol_pattern_config uut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
        .reg_hit_r(reg_hit_r), .rate_cfg_r(rate_cfg_r),
        .upper_rate_reserved_r(upper_rate_reserved_r),
        .lower_rate_reserved_r(lower_rate_reserved_r),
        .sym0_r(sym0_r), .sym1_r(sym1_r), .sym2_r(sym2_r), .sym3_r(sym3_r)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------
    // checking and reporting
    // ------------------------------------------------------------
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test

    task automatic cmp_rd(input logic [8:0] got, input logic [8:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t read got %h exp %h", $time, got, exp);
        end
    endtask : cmp_rd

    task automatic cmp_cfg(input logic [20:0] got, input logic [20:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t config got %h exp %h", $time, got, exp);
        end
    endtask : cmp_cfg

    // msb first: only the top length-plus-one bits survive
    function automatic logic [20:0] exp16(input logic [7:0] h, input logic [7:0] l,
                                          input logic [3:0] n);
        return {({h, l} & (16'hffff << (4'hf - n))), {1'b0, n} + 5'h01};
    endfunction : exp16

    function automatic logic [20:0] exp8(input logic [7:0] p, input logic [2:0] n);
        return 21'({(p & (8'hff << (3'h7 - n))), {1'b0, n} + 4'h1});
    endfunction : exp8

    // read results are valid just after the taking edge and are checked 1 ns later
    always @(posedge clk_sys)
    begin
        if (reg_rd === 1'b1 && sys_rst === 1'b0)
        begin
            #1;
            if (rq.size() == 0)
                cmp_rd({reg_hit_r, reg_rdata_r}, 9'h1ff);
            else
                cmp_rd({reg_hit_r, reg_rdata_r}, rq.pop_front());
        end
    end

    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end

    // ------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------
    // one request per edge; the model notes read data before the write lands
    task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        int idx;
        idx = int'(a) - int'(tx_symbol_pkg::ADDR_RATE);
        @(posedge clk_sys);
        reg_wr    <= w;
        reg_rd    <= r;
        reg_addr  <= a;
        reg_wdata <= d;
        if (r)
            rq.push_back((idx >= 0 && idx < 9) ? {1'b1, mem[idx]} : 9'h000);
        if (w && idx >= 0 && idx < 9)
            mem[idx] = (idx == 8) ? (d & 8'h77) : d;
    endtask : op

    task automatic rd_all;
        for (int i = 0; i < 9; i++)
            op(1'b0, 1'b1, tx_symbol_pkg::ADDR_RATE + 8'(i), 8'h00);
        op(1'b0, 1'b1, 8'h4b, 8'h00);
        op(1'b0, 1'b1, 8'h55, 8'h00);
    endtask : rd_all

    task automatic chk_cfg(input string name);
        op(1'b0, 1'b0, 8'h00, 8'h00);
        repeat (2) @(posedge clk_sys);
        #1;
        cmp_cfg(21'(rate_cfg_r), 21'(mem[0]));
        cmp_cfg(21'(upper_rate_reserved_r), 21'(mem[0][6:4] < 3'h2));
        cmp_cfg(21'(lower_rate_reserved_r), 21'(mem[0][2:0] < 3'h2));
        cmp_cfg(21'(sym0_r), exp16(mem[1], mem[2], mem[7][3:0]));
        cmp_cfg(21'(sym1_r), exp16(mem[3], mem[4], mem[7][7:4]));
        cmp_cfg(21'(sym2_r), exp8(mem[5], mem[8][2:0]));
        cmp_cfg(21'(sym3_r), exp8(mem[6], mem[8][6:4]));
        rd_all();
        op(1'b0, 1'b0, 8'h00, 8'h00);
        repeat (3) @(posedge clk_sys);
        $display("test %s done", name);
    endtask : chk_cfg

    task automatic do_reset(input int n);
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        // drop the strobes so a request left standing is not taken again after release
        reg_wr  <= 1'b0;
        reg_rd  <= 1'b0;
        repeat (n) @(posedge clk_sys);
        sys_rst <= 1'b0;
        for (int i = 0; i < 9; i++)
            mem[i] = 8'h00;
    endtask : do_reset

    initial
    begin
        logic [7:0] v;
        sys_rst   = 1'b1;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        for (int i = 0; i < 9; i++)
            mem[i] = 8'h00;
        void'($urandom(31036));
        do_reset(10);
        chk_cfg("reset");
        // every rate code in both fields, both subcarrier settings
        for (int i = 0; i < 8; i++)
        begin
            v = {i[0], i[2:0], ~i[0], 3'(7 - i)};
            op(1'b1, 1'b0, tx_symbol_pkg::ADDR_RATE, v);
            chk_cfg("rate");
        end
        // length boundaries, reserved bits of the second length register
        foreach (mem[i])
            op(1'b1, 1'b0, tx_symbol_pkg::ADDR_RATE + 8'(i), 8'($urandom));
        for (int i = 0; i < 4; i++)
        begin
            v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : (i == 2) ? 8'h7a : 8'h88;
            op(1'b1, 1'b0, tx_symbol_pkg::ADDR_LEN01, v);
            op(1'b1, 1'b1, tx_symbol_pkg::ADDR_LEN23, v);
            chk_cfg("length");
        end
        // back to back traffic, unmapped writes and reads, same cycle read and write
        for (int i = 0; i < 80; i++)
        begin
            v = 8'h4a + 8'($urandom_range(12));
            op(1'($urandom), 1'($urandom), v, 8'($urandom));
        end
        chk_cfg("random");
        // a second reset in mid-run brings every register back to zero; symbol counts then read one
        op(1'b1, 1'b0, tx_symbol_pkg::ADDR_P2, 8'hc3);
        do_reset(3);
        chk_cfg("reset again");
        end_of_test();
    end

endmodule : tb_top
